// ==== hdl/fcpwm_defines.svh ====
`ifndef FCPWM_DEFINES_SVH
`define FCPWM_DEFINES_SVH

// ----------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------
`define FCPWM_ADDR_AUX      8'h91
`define FCPWM_ADDR_D2H      8'hB1
`define FCPWM_ADDR_D2L      8'hB2
`define FCPWM_ADDR_D3H      8'hB3
`define FCPWM_ADDR_D3L      8'hB4
`define FCPWM_ADDR_CTRL     8'hB5
`define FCPWM_ADDR_D0H      8'hBC
`define FCPWM_ADDR_D0L      8'hBD
`define FCPWM_ADDR_D1H      8'hBE
`define FCPWM_ADDR_D1L      8'hBF
`define FCPWM_ADDR_IEN1     8'hB8
`define FCPWM_ADDR_IRCON    8'hC0
`define FCPWM_ADDR_MAXH     8'hCE
`define FCPWM_ADDR_MAXL     8'hCF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FCPWM_AUX_PORTSEL   1
`define FCPWM_CTRL_CS_HI    7
`define FCPWM_CTRL_CS_LO    5
`define FCPWM_IDLE_BIT      7
`define FCPWM_IRQ_BIT       0

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define FCPWM_RST_BYTE      8'h00
`define FCPWM_RST_MAXL      8'hFF
`define FCPWM_RST_DUTY      10'h000
`define FCPWM_RST_MAX       10'h0FF
`define FCPWM_ZERO10        10'h000
`define FCPWM_ONE10         10'h001
`define FCPWM_IRQ_VECTOR    16'h0043
`define FCPWM_ZERO4         4'h0
`define FCPWM_ONE4          4'h1

// ----------------------------------------------------------------------
// prescaler terminal counts (clocks per tick minus one), tick gap counter top, pin sync reset
// ----------------------------------------------------------------------
`define FCPWM_DIV1_LIM      4'h0
`define FCPWM_DIV2_LIM      4'h1
`define FCPWM_DIV4_LIM      4'h3
`define FCPWM_DIV6_LIM      4'h5
`define FCPWM_DIV8_LIM      4'h7
`define FCPWM_DIV12_LIM     4'hB
`define FCPWM_GAP_TOP       4'hF
`define FCPWM_RST_SYNC      3'h0

`endif

// ==== hdl/fcpwm_pkg.sv ====
package fcpwm_pkg;
  `include "fcpwm_defines.svh"

  typedef enum logic [2:0] {
    FCPWM_CS_DIV1  = 3'b000,
    FCPWM_CS_DIV2  = 3'b001,
    FCPWM_CS_DIV4  = 3'b010,
    FCPWM_CS_DIV6  = 3'b011,
    FCPWM_CS_DIV8  = 3'b100,
    FCPWM_CS_DIV12 = 3'b101,
    FCPWM_CS_T0OVF = 3'b110,
    FCPWM_CS_T0PIN = 3'b111
  } fcpwm_clksel_t;

  typedef struct packed {
    logic       chIdleLevel;
    logic [9:0] chDutyValue;
  } fcpwm_chan_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fcpwm_sfr_t;
endpackage : fcpwm_pkg

// ==== hdl/fcpwm_tick_gen.sv ====
`timescale 1ns/10ps
`include "fcpwm_defines.svh"
module fcpwm_tick_gen
  import fcpwm_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          resetn,
  // selection and sources
  input  wire fcpwm_clksel_t countClockSelect,
  input  wire logic          timer0Overflow,
  input  wire logic          timer0ExtInput,
  // tick out
  output logic               countTick
);
  // ----------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------
  logic [3:0] preCount;
  logic [3:0] divLimit;
  logic [2:0] pinSync;
  logic       pinLevel;

  always_comb begin
    unique case (countClockSelect)
      FCPWM_CS_DIV1:  divLimit = `FCPWM_DIV1_LIM;
      FCPWM_CS_DIV2:  divLimit = `FCPWM_DIV2_LIM;
      FCPWM_CS_DIV4:  divLimit = `FCPWM_DIV4_LIM;
      FCPWM_CS_DIV6:  divLimit = `FCPWM_DIV6_LIM;
      FCPWM_CS_DIV8:  divLimit = `FCPWM_DIV8_LIM;
      FCPWM_CS_DIV12: divLimit = `FCPWM_DIV12_LIM;
      FCPWM_CS_T0OVF: divLimit = `FCPWM_DIV1_LIM;
      FCPWM_CS_T0PIN: divLimit = `FCPWM_DIV1_LIM;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn || preCount >= divLimit) begin
      preCount <= `FCPWM_ZERO4;
    end else begin
      preCount <= preCount + `FCPWM_ONE4;
    end
  end

  // ----------------------------------------------------------------------
  // external pin: three stages, rising edge once stages two and three agree
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinSync <= `FCPWM_RST_SYNC;
    end else begin
      pinSync <= {pinSync[1:0], timer0ExtInput};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pinLevel <= 1'b0;
    end else if (pinSync[2] == pinSync[1]) begin
      pinLevel <= pinSync[2];
    end
  end

  always_comb begin
    unique case (countClockSelect)
      FCPWM_CS_T0OVF: countTick = timer0Overflow;
      FCPWM_CS_T0PIN: countTick = pinSync[2] & pinSync[1] & ~pinLevel;
      default:        countTick = (preCount >= divLimit);
    endcase
  end
endmodule : fcpwm_tick_gen

// ==== hdl/fcpwm_unit.sv ====
`timescale 1ns/10ps
`include "fcpwm_defines.svh"
module fcpwm_unit
  import fcpwm_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // special function register access
  input  wire fcpwm_sfr_t  sfrReq,
  output logic [7:0]       sfrRdata,
  output logic             sfrHit,
  // counting sources
  input  wire logic        timer0Overflow,
  input  wire logic        timer0ExtInput,
  // interrupt
  output logic             overflowIrq,
  output logic [15:0]      irqVector,
  // waveform pins
  output logic [3:0]       port4Pwm,
  output logic [3:0]       port2Pwm,
  output logic [3:0]       port4PwmSel,
  output logic [3:0]       port2PwmSel
);
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0]  auxiliaryRouting;
  logic [7:0]  pulseControl;
  fcpwm_chan_t chanCfg [4];
  logic [9:0]  periodMaxValue;
  logic        overflowIrqFlag;
  logic        overflowIrqEnable;
  logic [9:0]  pwmCount;
  logic [3:0]  pwmLevel;
  logic        countTick;
  logic        overflowEvent;
  logic        outputPortSelect;
  fcpwm_clksel_t countClockSelect;

  assign outputPortSelect = auxiliaryRouting[`FCPWM_AUX_PORTSEL];
  assign countClockSelect = fcpwm_clksel_t'(pulseControl[`FCPWM_CTRL_CS_HI:`FCPWM_CTRL_CS_LO]);

  function automatic logic wrHit(input fcpwm_sfr_t r, input logic [7:0] a);
    wrHit = r.write && (r.addr == a);
  endfunction : wrHit

  function automatic logic [7:0] highAddr(input int ch);
    unique case (ch)
      0:       highAddr = `FCPWM_ADDR_D0H;
      1:       highAddr = `FCPWM_ADDR_D1H;
      2:       highAddr = `FCPWM_ADDR_D2H;
      default: highAddr = `FCPWM_ADDR_D3H;
    endcase
  endfunction : highAddr

  function automatic logic [7:0] lowAddr(input int ch);
    unique case (ch)
      0:       lowAddr = `FCPWM_ADDR_D0L;
      1:       lowAddr = `FCPWM_ADDR_D1L;
      2:       lowAddr = `FCPWM_ADDR_D2L;
      default: lowAddr = `FCPWM_ADDR_D3L;
    endcase
  endfunction : lowAddr

  always_ff @(posedge clock) begin
    if (!resetn) begin
      auxiliaryRouting <= `FCPWM_RST_BYTE;
    end else if (wrHit(sfrReq, `FCPWM_ADDR_AUX)) begin
      auxiliaryRouting <= sfrReq.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pulseControl <= `FCPWM_RST_BYTE;
    end else if (wrHit(sfrReq, `FCPWM_ADDR_CTRL)) begin
      pulseControl <= {sfrReq.wdata[7:5], 1'b0, sfrReq.wdata[3:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        chanCfg[i] <= '{1'b0, `FCPWM_RST_DUTY};
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wrHit(sfrReq, highAddr(i))) begin
          chanCfg[i].chIdleLevel      <= sfrReq.wdata[`FCPWM_IDLE_BIT];
          chanCfg[i].chDutyValue[9:8] <= sfrReq.wdata[1:0];
        end
        if (wrHit(sfrReq, lowAddr(i))) begin
          chanCfg[i].chDutyValue[7:0] <= sfrReq.wdata;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      periodMaxValue <= `FCPWM_RST_MAX;
    end else begin
      if (wrHit(sfrReq, `FCPWM_ADDR_MAXH)) begin
        periodMaxValue[9:8] <= sfrReq.wdata[1:0];
      end
      if (wrHit(sfrReq, `FCPWM_ADDR_MAXL)) begin
        periodMaxValue[7:0] <= sfrReq.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt flag and enable
  // ----------------------------------------------------------------------
  // only bit 0 of the shared request/enable bytes belongs here
  always_ff @(posedge clock) begin
    if (!resetn) begin
      overflowIrqEnable <= 1'b0;
    end else if (wrHit(sfrReq, `FCPWM_ADDR_IEN1)) begin
      overflowIrqEnable <= sfrReq.wdata[`FCPWM_IRQ_BIT];
    end
  end

  // set beats a same-cycle software clear so no overflow is lost
  always_ff @(posedge clock) begin
    if (!resetn) begin
      overflowIrqFlag <= 1'b0;
    end else if (overflowEvent) begin
      overflowIrqFlag <= 1'b1;
    end else if (wrHit(sfrReq, `FCPWM_ADDR_IRCON)) begin
      overflowIrqFlag <= sfrReq.wdata[`FCPWM_IRQ_BIT];
    end
  end

  assign overflowIrq = overflowIrqFlag & overflowIrqEnable;
  assign irqVector   = `FCPWM_IRQ_VECTOR;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always_comb begin
    sfrRdata = `FCPWM_RST_BYTE;
    sfrHit   = 1'b1;
    unique case (sfrReq.addr)
      `FCPWM_ADDR_AUX:   sfrRdata = auxiliaryRouting;
      `FCPWM_ADDR_CTRL:  sfrRdata = pulseControl;
      `FCPWM_ADDR_D0H:   sfrRdata = {chanCfg[0].chIdleLevel, 5'h00, chanCfg[0].chDutyValue[9:8]};
      `FCPWM_ADDR_D0L:   sfrRdata = chanCfg[0].chDutyValue[7:0];
      `FCPWM_ADDR_D1H:   sfrRdata = {chanCfg[1].chIdleLevel, 5'h00, chanCfg[1].chDutyValue[9:8]};
      `FCPWM_ADDR_D1L:   sfrRdata = chanCfg[1].chDutyValue[7:0];
      `FCPWM_ADDR_D2H:   sfrRdata = {chanCfg[2].chIdleLevel, 5'h00, chanCfg[2].chDutyValue[9:8]};
      `FCPWM_ADDR_D2L:   sfrRdata = chanCfg[2].chDutyValue[7:0];
      `FCPWM_ADDR_D3H:   sfrRdata = {chanCfg[3].chIdleLevel, 5'h00, chanCfg[3].chDutyValue[9:8]};
      `FCPWM_ADDR_D3L:   sfrRdata = chanCfg[3].chDutyValue[7:0];
      `FCPWM_ADDR_MAXH:  sfrRdata = {6'h00, periodMaxValue[9:8]};
      `FCPWM_ADDR_MAXL:  sfrRdata = periodMaxValue[7:0];
      `FCPWM_ADDR_IEN1:  sfrRdata = {7'h00, overflowIrqEnable};
      `FCPWM_ADDR_IRCON: sfrRdata = {7'h00, overflowIrqFlag};
      default:           sfrHit   = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // counting clock
  // ----------------------------------------------------------------------
  fcpwm_tick_gen fcpwm_tick_gen_i (
    .clock            (clock),
    .resetn           (resetn),
    .countClockSelect (countClockSelect),
    .timer0Overflow   (timer0Overflow),
    .timer0ExtInput   (timer0ExtInput),
    .countTick        (countTick)
  );

  // ----------------------------------------------------------------------
  // shared counter
  // ----------------------------------------------------------------------
  // >= also recovers when the maximum is lowered below the running count
  assign overflowEvent = countTick && (pwmCount >= periodMaxValue);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pwmCount <= `FCPWM_ZERO10;
    end else if (overflowEvent) begin
      pwmCount <= `FCPWM_ZERO10;
    end else if (countTick) begin
      pwmCount <= pwmCount + `FCPWM_ONE10;
    end
  end

  // ----------------------------------------------------------------------
  // waveforms
  // ----------------------------------------------------------------------
  // duty above maximum simply gives a full-period active level
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pwmLevel <= `FCPWM_ZERO4;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!pulseControl[i]) begin
          pwmLevel[i] <= chanCfg[i].chIdleLevel;
        end else if (pwmCount < chanCfg[i].chDutyValue) begin
          pwmLevel[i] <= ~chanCfg[i].chIdleLevel;
        end else begin
          pwmLevel[i] <= chanCfg[i].chIdleLevel;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      port4Pwm    <= `FCPWM_ZERO4;
      port2Pwm    <= `FCPWM_ZERO4;
      port4PwmSel <= `FCPWM_ZERO4;
      port2PwmSel <= `FCPWM_ZERO4;
    end else begin
      port4Pwm    <= outputPortSelect ? `FCPWM_ZERO4 : pwmLevel;
      port2Pwm    <= outputPortSelect ? pwmLevel : `FCPWM_ZERO4;
      port4PwmSel <= {4{~outputPortSelect}};
      port2PwmSel <= {4{outputPortSelect}};
    end
  end

  // ----------------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------------
  // gap is only trusted once a tick has passed under an unchanged select
  logic [3:0] tickGap;
  logic       gapValid;

  function automatic logic [3:0] gapLimit(input fcpwm_clksel_t code);
    unique case (code)
      FCPWM_CS_DIV2:  gapLimit = `FCPWM_DIV2_LIM;
      FCPWM_CS_DIV4:  gapLimit = `FCPWM_DIV4_LIM;
      FCPWM_CS_DIV6:  gapLimit = `FCPWM_DIV6_LIM;
      FCPWM_CS_DIV8:  gapLimit = `FCPWM_DIV8_LIM;
      FCPWM_CS_DIV12: gapLimit = `FCPWM_DIV12_LIM;
      FCPWM_CS_DIV1,
      FCPWM_CS_T0OVF,
      FCPWM_CS_T0PIN: gapLimit = `FCPWM_DIV1_LIM;
    endcase
  endfunction : gapLimit

  always_ff @(posedge clock) begin
    if (!resetn || wrHit(sfrReq, `FCPWM_ADDR_CTRL)) begin
      tickGap  <= `FCPWM_ZERO4;
      gapValid <= 1'b0;
    end else if (countTick) begin
      tickGap  <= `FCPWM_ZERO4;
      gapValid <= 1'b1;
    end else if (tickGap != `FCPWM_GAP_TOP) begin
      tickGap  <= tickGap + `FCPWM_ONE4;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_overflow;
    overflowEvent;
  endsequence

  sequence s_clear_write;
    wrHit(sfrReq, `FCPWM_ADDR_IRCON) && !sfrReq.wdata[`FCPWM_IRQ_BIT];
  endsequence

  sequence s_ch0_trailing;
    pulseControl[0] && pwmCount >= chanCfg[0].chDutyValue;
  endsequence

  sequence s_ch1_zero_high;
    chanCfg[1].chDutyValue == `FCPWM_ZERO10 && chanCfg[1].chIdleLevel;
  endsequence

  sequence s_div_tick;
    countTick && gapValid && countClockSelect != FCPWM_CS_T0OVF
      && countClockSelect != FCPWM_CS_T0PIN;
  endsequence

  chk_count_restart: assert property (@(posedge clock) disable iff (!resetn)
    s_overflow |=> pwmCount == `FCPWM_ZERO10)
    else $error("counter not restarted after overflow");
  chk_count_bound: assert property (@(posedge clock) disable iff (!resetn)
    countTick && !overflowEvent |=> pwmCount == $past(pwmCount) + `FCPWM_ONE10)
    else $error("counter did not advance");
  chk_flag_set: assert property (@(posedge clock) disable iff (!resetn)
    s_overflow |=> overflowIrqFlag)
    else $error("overflow did not set flag");
  chk_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    overflowIrqFlag && !wrHit(sfrReq, `FCPWM_ADDR_IRCON) |=> overflowIrqFlag)
    else $error("flag cleared without software");
  chk_irq_gate: assert property (@(posedge clock) disable iff (!resetn)
    wrHit(sfrReq, `FCPWM_ADDR_IEN1) && !sfrReq.wdata[`FCPWM_IRQ_BIT] |=> !overflowIrq)
    else $error("interrupt request not gated by enable");
  chk_zero_duty: assert property (@(posedge clock) disable iff (!resetn)
    chanCfg[0].chDutyValue == `FCPWM_ZERO10 ##1 chanCfg[0].chDutyValue == `FCPWM_ZERO10
    |-> pwmLevel[0] == $past(chanCfg[0].chIdleLevel))
    else $error("zero duty channel left idle level");
  chk_disabled_idle: assert property (@(posedge clock) disable iff (!resetn)
    !pulseControl[1] ##1 !pulseControl[1] |-> pwmLevel[1] == $past(chanCfg[1].chIdleLevel))
    else $error("disabled channel not at idle level");
  chk_leader_pulse: assert property (@(posedge clock) disable iff (!resetn)
    pulseControl[0] && pwmCount < chanCfg[0].chDutyValue
    |=> pwmLevel[0] == ~$past(chanCfg[0].chIdleLevel))
    else $error("leader pulse level wrong");
  chk_port_route: assert property (@(posedge clock) disable iff (!resetn)
    !outputPortSelect |=> port2Pwm == 4'h0 && port4Pwm == $past(pwmLevel))
    else $error("outputs on wrong port");
  chk_max_reset: assert property (@(posedge clock)
    $rose(resetn) |-> periodMaxValue == `FCPWM_RST_MAX)
    else $error("maximum reset value wrong");
  chk_count_hold: assert property (@(posedge clock) disable iff (!resetn)
    !countTick |=> pwmCount == $past(pwmCount))
    else $error("counter moved without a tick");
  chk_flag_clear: assert property (@(posedge clock) disable iff (!resetn)
    s_clear_write and !overflowEvent |=> !overflowIrqFlag)
    else $error("software clear of flag lost");
  chk_trailing_idle: assert property (@(posedge clock) disable iff (!resetn)
    s_ch0_trailing |=> pwmLevel[0] == $past(chanCfg[0].chIdleLevel))
    else $error("trailing part not at idle level");
  chk_zero_high: assert property (@(posedge clock) disable iff (!resetn)
    s_ch1_zero_high |=> pwmLevel[1])
    else $error("zero duty idle high channel not high");
  chk_port2_route: assert property (@(posedge clock) disable iff (!resetn)
    outputPortSelect |=> port4Pwm == `FCPWM_ZERO4 && port2Pwm == $past(pwmLevel))
    else $error("outputs not on port 2");
  chk_port_select: assert property (@(posedge clock) disable iff (!resetn)
    outputPortSelect |=> (&port2PwmSel) && !(|port4PwmSel))
    else $error("port select flags wrong");
  chk_tick_spacing: assert property (@(posedge clock) disable iff (!resetn)
    s_div_tick |-> tickGap == gapLimit(countClockSelect))
    else $error("divided tick spacing wrong");
endmodule : fcpwm_unit

// ==== tb/fcpwm_unit_tb.sv ====
`timescale 1ns/10ps
`include "fcpwm_defines.svh"
module fcpwm_unit_tb
  import fcpwm_pkg::*;
;
  // ----------------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------------
  localparam int LIMIT = 20000;
  localparam logic [7:0] RST_ADDR [14] = '{`FCPWM_ADDR_AUX, `FCPWM_ADDR_D2H, `FCPWM_ADDR_D2L,
    `FCPWM_ADDR_D3H, `FCPWM_ADDR_D3L, `FCPWM_ADDR_CTRL, `FCPWM_ADDR_D0H, `FCPWM_ADDR_D0L,
    `FCPWM_ADDR_D1H, `FCPWM_ADDR_D1L, `FCPWM_ADDR_IEN1, `FCPWM_ADDR_IRCON, `FCPWM_ADDR_MAXH,
    `FCPWM_ADDR_MAXL};
  localparam logic [7:0] RW_ADDR [5] = '{`FCPWM_ADDR_D0H, `FCPWM_ADDR_D0L, `FCPWM_ADDR_MAXH,
    `FCPWM_ADDR_MAXL, `FCPWM_ADDR_CTRL};
  localparam logic [7:0] RW_VAL [5] = '{8'h83, 8'hFF, 8'h03, 8'hFF, 8'hEF};
  // tick spacing in clocks for select codes 000..111
  localparam int SPACING [8] = '{1, 2, 4, 6, 8, 12, 4, 8};

  logic        clock          = 1'b0;
  logic        resetn         = 1'b0;
  fcpwm_sfr_t  sfrReq         = '0;
  logic        timer0Overflow = 1'b0;
  logic        timer0ExtInput = 1'b0;
  logic        t0Run          = 1'b1;
  logic [3:0]  srcCnt         = 4'h0;
  logic [7:0]  sfrRdata;
  logic        sfrHit;
  logic        overflowIrq;
  logic [15:0] irqVector;
  logic [3:0]  port4Pwm;
  logic [3:0]  port2Pwm;
  logic [3:0]  port4PwmSel;
  logic [3:0]  port2PwmSel;
  int          nErrors        = 0;
  int          testsRun       = 0;
  int          cycles         = 0;

  always #4 clock = ~clock;

  // timer 0 overflow every 4 clocks, pin rising edge every 8 clocks
  always @(posedge clock) begin
    srcCnt         <= srcCnt + 4'h1;
    timer0Overflow <= t0Run && (srcCnt[1:0] == 2'h0);
    timer0ExtInput <= srcCnt[2];
  end

  fcpwm_unit fcpwm_unit_i (
    .clock          (clock),
    .resetn         (resetn),
    .sfrReq         (sfrReq),
    .sfrRdata       (sfrRdata),
    .sfrHit         (sfrHit),
    .timer0Overflow (timer0Overflow),
    .timer0ExtInput (timer0ExtInput),
    .overflowIrq    (overflowIrq),
    .irqVector      (irqVector),
    .port4Pwm       (port4Pwm),
    .port2Pwm       (port2Pwm),
    .port4PwmSel    (port4PwmSel),
    .port2PwmSel    (port2PwmSel)
  );

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic finalReport;
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finalReport

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles >= LIMIT) begin
      nErrors++;
      finalReport();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic waitCycles(input int n);
    repeat (n) @(posedge clock);
  endtask : waitCycles

  task automatic sfrWrite(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    sfrReq <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    sfrReq.write <= 1'b0;
  endtask : sfrWrite

  task automatic sfrRead(input logic [7:0] addr, output logic [7:0] data, output logic hit);
    @(posedge clock);
    sfrReq <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clock);
    data = sfrRdata;
    hit  = sfrHit;
    @(posedge clock);
    sfrReq.read <= 1'b0;
  endtask : sfrRead

  // channel 0 shape, with channels 3..1 expected to stand at 1,0,1
  task automatic measure(input int n, output int rises, output int highs, output int bad);
    logic prev;
    rises = 0;
    highs = 0;
    bad   = 0;
    @(negedge clock);
    prev = port4Pwm[0];
    repeat (n) begin
      @(negedge clock);
      if (port4Pwm[0] === 1'b1) highs++;
      if (port4Pwm[0] === 1'b1 && prev === 1'b0) rises++;
      if (port4Pwm[3:1] !== 3'b101) bad++;
      prev = port4Pwm[0];
    end
  endtask : measure

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic testResetValues;
    logic [7:0] d;
    logic       h;
    for (int i = 0; i < 14; i++) begin
      sfrRead(RST_ADDR[i], d, h);
      check(d, (i == 13) ? `FCPWM_RST_MAXL : 8'h00, "reset value");
      check(h, 1'b1, "address hit");
    end
    sfrRead(8'h90, d, h);
    check({d, 7'h00, h}, 16'h0000, "unmapped read");
    check(irqVector, 16'h0043, "vector");
    check({port4PwmSel, port2PwmSel}, 8'hF0, "default routing");
  endtask : testResetValues

  task automatic testFieldAccess;
    logic [7:0] d;
    logic       h;
    sfrWrite(8'h90, 8'hFF);
    for (int i = 0; i < 5; i++) sfrWrite(RW_ADDR[i], 8'hFF);
    for (int i = 0; i < 5; i++) begin
      sfrRead(RW_ADDR[i], d, h);
      check(d, RW_VAL[i], "field readback");
    end
    sfrRead(8'h90, d, h);
    check(d, 8'h00, "unmapped after write");
    // second reset in mid-run must bring back every reset value
    @(posedge clock);
    resetn <= 1'b0;
    waitCycles(3);
    resetn <= 1'b1;
    testResetValues();
  endtask : testFieldAccess

  task automatic setShape(input logic [9:0] mx, input logic [9:0] duty, input logic idle);
    sfrWrite(`FCPWM_ADDR_MAXH, {6'h00, mx[9:8]});
    sfrWrite(`FCPWM_ADDR_MAXL, mx[7:0]);
    sfrWrite(`FCPWM_ADDR_D0H, {idle, 5'h00, duty[9:8]});
    sfrWrite(`FCPWM_ADDR_D0L, duty[7:0]);
  endtask : setShape

  task automatic testShapes;
    int r;
    int hi;
    int b;
    int p;
    logic [9:0] mx [3];
    logic [9:0] dt [3];
    mx = '{10'h003, 10'h003, 10'h103};
    dt = '{10'h002, 10'h001, 10'h101};
    sfrWrite(`FCPWM_ADDR_D1H, 8'h80);
    sfrWrite(`FCPWM_ADDR_D3H, 8'h80);
    sfrWrite(`FCPWM_ADDR_D3L, 8'h05);
    sfrWrite(`FCPWM_ADDR_CTRL, 8'h07);
    for (int i = 0; i < 3; i++) begin
      p = int'(mx[i]) + 1;
      setShape(mx[i], dt[i], i == 1);
      waitCycles(2 * p + 4);
      measure(2 * p, r, hi, b);
      check(r, 2, "periods in window");
      check(hi, 2 * ((i == 1) ? p - int'(dt[i]) : int'(dt[i])), "leader pulse");
      check(b, 0, "static channels");
    end
    check({port4PwmSel, port2PwmSel, port2Pwm}, 12'hF00, "port 4 routing");
  endtask : testShapes

  task automatic testClockSelect;
    int r;
    int hi;
    int b;
    setShape(10'h003, 10'h002, 1'b0);
    for (int c = 0; c < 8; c++) begin
      sfrWrite(`FCPWM_ADDR_CTRL, {c[2:0], 5'h07});
      waitCycles(8 * SPACING[c] + 4);
      measure(12 * SPACING[c], r, hi, b);
      check(r, 3, "select periods");
      check(hi, 6 * SPACING[c], "select pulse");
    end
  endtask : testClockSelect

  task automatic testRouting;
    sfrWrite(`FCPWM_ADDR_AUX, 8'h02);
    waitCycles(4);
    @(negedge clock);
    check({port2PwmSel, port4PwmSel, port4Pwm}, 12'hF00, "port 2 routing");
    check(port2Pwm[3:1], 3'b101, "port 2 levels");
    sfrWrite(`FCPWM_ADDR_AUX, 8'h00);
  endtask : testRouting

  task automatic testInterrupt;
    logic [7:0] d;
    logic       h;
    sfrWrite(`FCPWM_ADDR_CTRL, 8'h07);
    waitCycles(10);
    @(negedge clock);
    check(overflowIrq, 1'b0, "request masked");
    sfrRead(`FCPWM_ADDR_IRCON, d, h);
    check(d[0], 1'b1, "flag on overflow");
    // freeze counting so no further overflow can mask the clear
    @(posedge clock);
    t0Run <= 1'b0;
    sfrWrite(`FCPWM_ADDR_CTRL, 8'hC7);
    sfrWrite(`FCPWM_ADDR_IEN1, 8'h01);
    waitCycles(20);
    @(negedge clock);
    check(overflowIrq, 1'b1, "request held until cleared");
    sfrWrite(`FCPWM_ADDR_IRCON, 8'h00);
    sfrRead(`FCPWM_ADDR_IRCON, d, h);
    check({d[0], overflowIrq}, 2'b00, "flag cleared");
    @(posedge clock);
    t0Run <= 1'b1;
    waitCycles(40);
    @(negedge clock);
    check(overflowIrq, 1'b1, "request on timer 0 overflow");
    sfrWrite(`FCPWM_ADDR_IEN1, 8'h00);
    @(negedge clock);
    check(overflowIrq, 1'b0, "request disabled");
  endtask : testInterrupt

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    waitCycles(12);
    resetn <= 1'b1;
    testResetValues();
    testFieldAccess();
    testShapes();
    testClockSelect();
    testRouting();
    testInterrupt();
    finalReport();
  end
endmodule : fcpwm_unit_tb
